/* File: tcc_two_way_code_cache.sv */
// two-way set associative code cache with apb control and mapped contents
// ----------------------------------------------------------------
// Operation
// - two-way set associative, LRU victim choice
// - cache mode caches flash and execute_in_place fetches
// - two ways per set, 128-bit lines
// - hit/miss counts per region and access type
// - data, tag, valid, recent flag readable
// - content read-only in cache mode; lock blocks it entirely
// - update_freeze: no refills, hits still served
// - ram mode bypasses cache, no lookup
// - ram mode: data storage is read/write
// - invalidate, disable, ram-to-cache clear valids
// - per-set recent flag updated, picks victim
// - hit needs valid way with matching tag
// - line maps as four ascending words
// - data at 0x00F00000, info at 0x00F08000
// - cache-to-ram change clears the storage
// - counter_clear_reg write zeroes all counters
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module tcc_two_way_code_cache
  import tcc_pkg::*;
#(
  parameter int unsigned SETS = 64,
  parameter logic [31:0] CTRL_BASE = tcc_pkg::CTRL_BASE_DEF,
  parameter logic [31:0] FLASH_BASE = 32'h00000000,
  parameter logic [31:0] FLASH_SIZE = 32'h00100000,
  parameter logic [31:0] XIP_BASE = 32'h10000000,
  parameter logic [31:0] XIP_SIZE = 32'h10000000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic cpu_req_valid,
  input wire tcc_pkg::tcc_code_req_s cpu_req,
  output logic cpu_ready,
  output logic [31:0] cpu_rdata,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_resp_valid,
  input wire logic [127:0] mem_resp_line
);

  localparam int unsigned IDX_W = $clog2(SETS);
  localparam int unsigned ENT_W = IDX_W + 1;
  localparam int unsigned TAG_W = 32 - LINE_OFS_W - IDX_W;
  localparam logic [REGION_ADDR_W-1:0] DATA_LIMIT = REGION_ADDR_W'(SETS * WAYS * (LINE_W / 8));
  localparam logic [REGION_ADDR_W-1:0] INFO_LIMIT = REGION_ADDR_W'(SETS * WAYS * 4);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tcc_state_e state_r, state_nxt;
  logic enable_r, enable_nxt;
  logic mode_r, mode_nxt;
  logic lock_r, lock_nxt;
  logic freeze_r, freeze_nxt;
  logic [1:0] valid_r [SETS];
  logic [1:0] valid_nxt [SETS];
  logic [TAG_W-1:0] tag_r [SETS][WAYS];
  logic [TAG_W-1:0] tag_nxt [SETS][WAYS];
  logic [SETS-1:0] mru_r, mru_nxt;
  tcc_code_req_s req_r, req_nxt;
  logic alloc_r, alloc_nxt;
  logic way_r, way_nxt;
  logic [1:0] word_r, word_nxt;
  logic [ENT_W-1:0] erase_r, erase_nxt;
  logic pready_r, pready_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic cpu_ready_r, cpu_ready_nxt;
  logic [31:0] cpu_rdata_r, cpu_rdata_nxt;
  logic mem_req_r, mem_req_nxt;
  logic [31:0] mem_addr_r, mem_addr_nxt;
  logic [CNT_W-1:0] cnt_r [NUM_CNT];
  logic [CNT_W-1:0] cnt_nxt [NUM_CNT];
  logic [NUM_CNT-1:0] cnt_inc;
  logic cnt_clr;

  // storage port
  logic ram_en;
  logic [LINE_W/8-1:0] ram_be;
  logic [ENT_W-1:0] ram_addr;
  logic [LINE_W-1:0] ram_wdata;
  logic [LINE_W-1:0] ram_rdata;

  tcc_line_ram #(
    .WIDTH(LINE_W),
    .DEPTH(SETS * WAYS),
    .AW(ENT_W)
  ) u_line_ram (
    .clk(pclk),
    .en(ram_en),
    .be(ram_be),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic apb_take, cpu_take, cache_on, is_ctrl, is_data, is_info, cacheable, is_xip;
  logic [CTRL_ADDR_W-1:0] ctrl_ofs;
  logic [REGION_ADDR_W-1:0] reg_ofs;
  logic [ENT_W-1:0] data_ent, info_ent;
  logic [IDX_W-1:0] cpu_idx;
  logic [TAG_W-1:0] cpu_tag;
  logic hit0, hit1, hit;

  // requests are taken only in idle, and never in the cycle their answer leaves
  assign apb_take = psel && penable && !pready_r;
  assign cpu_take = cpu_req_valid && !cpu_ready_r;
  assign cache_on = enable_r && (mode_r == MODE_CACHE);
  assign is_ctrl = paddr[31:CTRL_ADDR_W] == CTRL_BASE[31:CTRL_ADDR_W];
  assign ctrl_ofs = paddr[CTRL_ADDR_W-1:0];
  assign reg_ofs = paddr[REGION_ADDR_W-1:0];
  assign is_data = (paddr[31:REGION_ADDR_W] == DATA_REGION_BASE[31:REGION_ADDR_W]) && (reg_ofs < DATA_LIMIT);
  assign is_info = (paddr[31:REGION_ADDR_W] == INFO_REGION_BASE[31:REGION_ADDR_W]) && (reg_ofs < INFO_LIMIT);
  assign data_ent = reg_ofs[LINE_OFS_W +: ENT_W];
  assign info_ent = reg_ofs[2 +: ENT_W];

  // fetch address split; region ranges come from module parameters
  assign cpu_idx = cpu_req.addr[LINE_OFS_W +: IDX_W];
  assign cpu_tag = cpu_req.addr[31 -: TAG_W];
  assign is_xip = (cpu_req.addr - XIP_BASE) < XIP_SIZE;
  assign cacheable = is_xip || ((cpu_req.addr - FLASH_BASE) < FLASH_SIZE);
  assign hit0 = valid_r[cpu_idx][0] && (tag_r[cpu_idx][0] == cpu_tag);
  assign hit1 = valid_r[cpu_idx][1] && (tag_r[cpu_idx][1] == cpu_tag);
  assign hit = hit0 || hit1;

  // ----------------------------------------------------------------
  // control, lookup and bus sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    enable_nxt = enable_r;
    mode_nxt = mode_r;
    lock_nxt = lock_r;
    freeze_nxt = freeze_r;
    valid_nxt = valid_r;
    tag_nxt = tag_r;
    mru_nxt = mru_r;
    req_nxt = req_r;
    alloc_nxt = alloc_r;
    way_nxt = way_r;
    word_nxt = word_r;
    erase_nxt = erase_r;
    pready_nxt = 1'b0;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    cpu_ready_nxt = 1'b0;
    cpu_rdata_nxt = cpu_rdata_r;
    mem_req_nxt = mem_req_r;
    mem_addr_nxt = mem_addr_r;
    cnt_inc = '0;
    cnt_clr = 1'b0;
    ram_en = 1'b0;
    ram_be = '0;
    ram_addr = '0;
    ram_wdata = '0;
    case (state_r)
      ST_IDLE: begin
        // the bus is served ahead of the cpu so software is never starved
        if (apb_take) begin
          pready_nxt = 1'b1;
          pslverr_nxt = 1'b0;
          prdata_nxt = '0;
          if (is_ctrl) begin
            if (pwrite) begin
              case (ctrl_ofs)
                OFS_ENABLE: begin
                  enable_nxt = pwdata[CTRL_BIT];
                  if (enable_r && !pwdata[CTRL_BIT]) begin
                    for (int s = 0; s < SETS; s++) valid_nxt[s] = 2'b00;
                  end
                end
                OFS_INVALIDATE: begin
                  if (pwdata[CTRL_BIT]) begin
                    for (int s = 0; s < SETS; s++) valid_nxt[s] = 2'b00;
                  end
                end
                OFS_PROF_CLEAR: cnt_clr = 1'b1;
                OFS_MODE: begin
                  mode_nxt = pwdata[CTRL_BIT];
                  if (mode_r == MODE_RAM && pwdata[CTRL_BIT] == MODE_CACHE) begin
                    for (int s = 0; s < SETS; s++) valid_nxt[s] = 2'b00;
                  end
                  if (mode_r == MODE_CACHE && pwdata[CTRL_BIT] == MODE_RAM) begin
                    // walk every entry to zero before anyone may use it as ram
                    pready_nxt = 1'b0;
                    erase_nxt = '0;
                    state_nxt = ST_ERASE;
                  end
                end
                OFS_LOCK: lock_nxt = pwdata[CTRL_BIT];
                OFS_FREEZE: freeze_nxt = pwdata[CTRL_BIT];
                default: begin
                  // counters are read-only; writes to them are dropped silently
                  pslverr_nxt = !(ctrl_ofs[11:8] == OFS_PROFILE[11:8]);
                end
              endcase
            end else begin
              case (ctrl_ofs)
                OFS_ENABLE: prdata_nxt[CTRL_BIT] = enable_r;
                OFS_MODE: prdata_nxt[CTRL_BIT] = mode_r;
                OFS_LOCK: prdata_nxt[CTRL_BIT] = lock_r;
                OFS_FREEZE: prdata_nxt[CTRL_BIT] = freeze_r;
                OFS_INVALIDATE, OFS_PROF_CLEAR: prdata_nxt = '0;
                default: begin
                  pslverr_nxt = 1'b1;
                  for (int n = 0; n < NUM_CNT; n++) begin
                    if (ctrl_ofs == OFS_PROFILE + PROFILE_STRIDE * 12'(n / 4) + 12'((n % 4) * 4)) begin
                      prdata_nxt = cnt_r[n];
                      pslverr_nxt = 1'b0;
                    end
                  end
                end
              endcase
            end
          end else if (is_data) begin
            if (lock_r) begin
              pslverr_nxt = 1'b1;
            end else if (pwrite) begin
              if (mode_r == MODE_RAM) begin
                ram_en = 1'b1;
                ram_be = (LINE_W / 8)'(pstrb) << (4 * reg_ofs[3:2]);
                ram_addr = data_ent;
                ram_wdata = {4{pwdata}};
              end else begin
                pslverr_nxt = 1'b1;
              end
            end else begin
              ram_en = 1'b1;
              ram_addr = data_ent;
              word_nxt = reg_ofs[3:2];
              pready_nxt = 1'b0;
              state_nxt = ST_APB_READ;
            end
          end else if (is_info) begin
            if (lock_r || pwrite) begin
              pslverr_nxt = 1'b1;
            end else begin
              prdata_nxt[TAG_W-1:0] = tag_r[info_ent[ENT_W-1:1]][info_ent[0]];
              prdata_nxt[INFO_VALID_BIT] = valid_r[info_ent[ENT_W-1:1]][info_ent[0]];
              prdata_nxt[INFO_RECENT_BIT] = mru_r[info_ent[ENT_W-1:1]] == info_ent[0];
            end
          end else begin
            pslverr_nxt = 1'b1;
          end
        end else if (cpu_take) begin
          req_nxt = cpu_req;
          word_nxt = cpu_req.addr[3:2];
          mem_addr_nxt = {cpu_req.addr[31:LINE_OFS_W], {LINE_OFS_W{1'b0}}};
          alloc_nxt = 1'b0;
          if (cache_on && cacheable) begin
            cnt_inc[{is_xip, !cpu_req.instr, !hit}] = 1'b1;
            if (hit) begin
              way_nxt = hit1 && !hit0;
              mru_nxt[cpu_idx] = hit1 && !hit0;
              ram_en = 1'b1;
              ram_addr = {cpu_idx, hit1 && !hit0};
              state_nxt = ST_HIT_READ;
            end else begin
              alloc_nxt = !freeze_r;
              way_nxt = !mru_r[cpu_idx];
              mem_req_nxt = 1'b1;
              state_nxt = ST_LINE_WAIT;
            end
          end else begin
            mem_req_nxt = 1'b1;
            state_nxt = ST_LINE_WAIT;
          end
        end
      end
      ST_HIT_READ: begin
        cpu_rdata_nxt = ram_rdata[32 * word_r +: 32];
        cpu_ready_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_LINE_WAIT: begin
        // the cpu stays stalled for as long as the memory takes
        if (mem_resp_valid) begin
          mem_req_nxt = 1'b0;
          cpu_rdata_nxt = mem_resp_line[32 * word_r +: 32];
          cpu_ready_nxt = 1'b1;
          if (alloc_r) begin
            ram_en = 1'b1;
            ram_be = '1;
            ram_addr = {req_r.addr[LINE_OFS_W +: IDX_W], way_r};
            ram_wdata = mem_resp_line;
            tag_nxt[req_r.addr[LINE_OFS_W +: IDX_W]][way_r] = req_r.addr[31 -: TAG_W];
            valid_nxt[req_r.addr[LINE_OFS_W +: IDX_W]][way_r] = 1'b1;
            mru_nxt[req_r.addr[LINE_OFS_W +: IDX_W]] = way_r;
          end
          state_nxt = ST_IDLE;
        end
      end
      ST_APB_READ: begin
        prdata_nxt = ram_rdata[32 * word_r +: 32];
        pready_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_ERASE: begin
        ram_en = 1'b1;
        ram_be = '1;
        ram_addr = erase_r;
        ram_wdata = '0;
        erase_nxt = erase_r + 1'b1;
        if (erase_r == ENT_W'(SETS * WAYS - 1)) begin
          for (int s = 0; s < SETS; s++) valid_nxt[s] = 2'b00;
          pready_nxt = 1'b1; // the mode write completes only after the walk
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      enable_r <= RST_ENABLE;
      mode_r <= RST_MODE;
      lock_r <= RST_LOCK;
      freeze_r <= RST_FREEZE;
      for (int s = 0; s < SETS; s++) begin
        valid_r[s] <= 2'b00;
        tag_r[s][0] <= '0;
        tag_r[s][1] <= '0;
      end
      mru_r <= '0;
      req_r <= '0;
      alloc_r <= 1'b0;
      way_r <= 1'b0;
      word_r <= 2'h0;
      erase_r <= '0;
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
      cpu_ready_r <= 1'b0;
      cpu_rdata_r <= 32'h00000000;
      mem_req_r <= 1'b0;
      mem_addr_r <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      enable_r <= enable_nxt;
      mode_r <= mode_nxt;
      lock_r <= lock_nxt;
      freeze_r <= freeze_nxt;
      valid_r <= valid_nxt;
      tag_r <= tag_nxt;
      mru_r <= mru_nxt;
      req_r <= req_nxt;
      alloc_r <= alloc_nxt;
      way_r <= way_nxt;
      word_r <= word_nxt;
      erase_r <= erase_nxt;
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      cpu_ready_r <= cpu_ready_nxt;
      cpu_rdata_r <= cpu_rdata_nxt;
      mem_req_r <= mem_req_nxt;
      mem_addr_r <= mem_addr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // profiling counters
  // ----------------------------------------------------------------
  // an event in the clearing cycle survives as a count of one
  always_comb begin
    for (int n = 0; n < NUM_CNT; n++) begin
      if (cnt_clr) begin
        cnt_nxt[n] = CNT_W'(cnt_inc[n]);
      end else begin
        cnt_nxt[n] = cnt_r[n] + CNT_W'(cnt_inc[n]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int n = 0; n < NUM_CNT; n++) cnt_r[n] <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign cpu_ready = cpu_ready_r;
  assign cpu_rdata = cpu_rdata_r;
  assign mem_req = mem_req_r;
  assign mem_addr = mem_addr_r;

endmodule
`default_nettype wire

/* File: tcc_pkg.sv */
// shared constants, types and layouts of the two-way code cache
package tcc_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_BASE_DEF = 32'h50001000;
  localparam logic [31:0] DATA_REGION_BASE = 32'h00F00000;
  localparam logic [31:0] INFO_REGION_BASE = 32'h00F08000;
  localparam int unsigned REGION_ADDR_W = 15;
  localparam int unsigned CTRL_ADDR_W = 12;

  // ----------------------------------------------------------------
  // control register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_PROFILE = 12'h400;
  localparam logic [11:0] PROFILE_STRIDE = 12'h020;
  localparam logic [11:0] OFS_ENABLE = 12'h500;
  localparam logic [11:0] OFS_INVALIDATE = 12'h504;
  localparam logic [11:0] OFS_PROF_CLEAR = 12'h510;
  localparam logic [11:0] OFS_MODE = 12'h514;
  localparam logic [11:0] OFS_LOCK = 12'h518;
  localparam logic [11:0] OFS_FREEZE = 12'h520;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_BIT = 0;
  localparam int unsigned INFO_VALID_BIT = 31;
  localparam int unsigned INFO_RECENT_BIT = 30;
  localparam logic MODE_CACHE = 1'b0;
  localparam logic MODE_RAM = 1'b1;
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_MODE = MODE_CACHE;
  localparam logic RST_LOCK = 1'b0;
  localparam logic RST_FREEZE = 1'b0;

  // ----------------------------------------------------------------
  // line geometry and profiling counters
  // ----------------------------------------------------------------
  localparam int unsigned LINE_W = 128;
  localparam int unsigned LINE_OFS_W = 4;
  localparam int unsigned WAYS = 2;
  localparam int unsigned NUM_CNT = 8;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned CNT_INSTR_HIT_COUNT = 0;
  localparam int unsigned CNT_LOAD_HIT_COUNT = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic instr;
  } tcc_code_req_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HIT_READ,
    ST_LINE_WAIT,
    ST_APB_READ,
    ST_ERASE
  } tcc_state_e;

endpackage

/* File: tcc_line_ram.sv */
// line storage of the cache: single port, byte enables, registered read
`timescale 1ns/1ps
`default_nettype none
module tcc_line_ram #(
  parameter int unsigned WIDTH = 128,
  parameter int unsigned DEPTH = 128,
  parameter int unsigned AW = 7
) (
  input wire logic clk,
  input wire logic en,
  input wire logic [WIDTH/8-1:0] be,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // byte lanes
  // ----------------------------------------------------------------
  // no reset on the array: contents are cleared by the erase walk
  // one process owns the whole array, the byte enables pick the lanes
  always_ff @(posedge clk) begin
    if (en) begin
      for (int b = 0; b < WIDTH / 8; b++) begin
        if (be[b]) begin
          mem[addr][b*8 +: 8] <= wdata[b*8 +: 8];
        end
      end
    end
  end

  // read data always comes out of a register
  always_ff @(posedge clk) begin
    if (en) begin
      rdata <= mem[addr];
    end
  end

endmodule
`default_nettype wire

/* File: tcc_two_way_code_cache_properties.sv */
// checker of the code cache port behaviour
`timescale 1ns/1ps
`default_nettype none
module tcc_two_way_code_cache_properties
  import tcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_req_valid,
  input wire logic cpu_ready,
  input wire logic [31:0] cpu_rdata,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_resp_valid
);
  import tcc_pkg::*;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  AST_PREADY_CAUSE: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready without access phase");
  AST_INFO_WRITE_REFUSED: assert property (pready && pwrite && paddr[31:15] == INFO_REGION_BASE[31:15] |-> pslverr)
    else $error("write to info region accepted");
  AST_CPU_READY_PULSE: assert property (cpu_ready |=> !cpu_ready) else $error("cpu_ready longer than one cycle");
  AST_CPU_READY_CAUSE: assert property (cpu_ready |-> cpu_req_valid && $past(cpu_req_valid))
    else $error("cpu_ready without held request");
  AST_MEM_ALIGNED: assert property (mem_req |-> mem_addr[3:0] == 4'h0) else $error("line fetch not aligned");
  AST_MEM_HELD: assert property (mem_req && !mem_resp_valid |=> mem_req && $stable(mem_addr))
    else $error("line fetch dropped early");
  AST_FILL_ANSWER: assert property (mem_req && mem_resp_valid |=> cpu_ready && !mem_req)
    else $error("fill not answered next cycle");
  AST_RDATA_HELD: assert property (!cpu_ready |-> $stable(cpu_rdata)) else $error("cpu_rdata moved");
  AST_MEM_CAUSE: assert property ($rose(mem_req) |-> $past(cpu_req_valid) && !cpu_ready)
    else $error("line fetch without request");
  COV_FILL: cover property (mem_req && mem_resp_valid);
endmodule
bind tcc_two_way_code_cache tcc_two_way_code_cache_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .cpu_req_valid(cpu_req_valid), .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .mem_req(mem_req),
  .mem_addr(mem_addr), .mem_resp_valid(mem_resp_valid));
`default_nettype wire

/* File: tcc_mem_model.sv */
// behavioural flash answering line fetches
`timescale 1ns/1ps
`default_nettype none
module tcc_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_resp_valid,
  output logic [127:0] mem_resp_line,
  output logic [15:0] fills
);
  logic [3:0] wait_r;
  // answers alternate fast and slow; off the pulse the line is inverted so stale data shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 4'h0;
      mem_resp_valid <= 1'b0;
      mem_resp_line <= '0;
      fills <= 16'h0;
    end else if (mem_req && !mem_resp_valid && wait_r == (fills[0] ? 4'h5 : 4'h1)) begin
      wait_r <= 4'h0;
      mem_resp_valid <= 1'b1;
      fills <= fills + 16'h1;
      for (int k = 0; k < 4; k++) begin
        mem_resp_line[k*32 +: 32] <= {mem_addr[31:4], 2'(k), 2'b00} ^ 32'h5A5A5A5A;
      end
    end else begin
      wait_r <= (mem_req && !mem_resp_valid) ? wait_r + 4'h1 : 4'h0;
      mem_resp_valid <= 1'b0;
      mem_resp_line <= ~mem_resp_line;
    end
  end
endmodule
`default_nettype wire

/* File: tcc_testbench.sv */
// self-checking bench of the code cache
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tcc_pkg::*;
  localparam logic [31:0] CB = CTRL_BASE_DEF;
  localparam logic [31:0] A = 32'h00000104;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_req_valid, cpu_ready, mem_req, mem_resp_valid;
  logic [31:0] paddr, pwdata, prdata, cpu_rdata, mem_addr, r;
  logic [127:0] mem_resp_line;
  logic [15:0] fills;
  logic e;
  tcc_code_req_s cpu_req;
  int errors = 0;
  int samples_checked = 0;
  tcc_two_way_code_cache dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cpu_req_valid(cpu_req_valid), .cpu_req(cpu_req), .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_resp_valid(mem_resp_valid), .mem_resp_line(mem_resp_line));
  tcc_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_resp_valid(mem_resp_valid), .mem_resp_line(mem_resp_line), .fills(fills));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_word(input logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'h5A5A5A5A;
  endfunction
  function automatic logic [31:0] cnt(input int rg, input int k);
    return CB + 32'h400 + 32'(rg * 32 + k * 4);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic hang();
    errors++;
    give_verdict();
  endtask
  // apb transfer; read data and error land in r and e
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // flop outputs read here still hold what this edge samples
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 400);
    if (pready !== 1'b1) hang();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // fetch held until cpu_ready; nf is the number of line fetches expected
  task automatic fetch(input logic [31:0] a, input logic i, input logic [15:0] nf);
    logic [15:0] f0;
    int n;
    f0 = fills;
    @(posedge pclk);
    cpu_req_valid <= 1'b1;
    cpu_req <= '{addr: a, instr: i};
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (cpu_ready !== 1'b1 && n < 200);
    if (cpu_ready !== 1'b1) hang();
    check(cpu_rdata, exp_word(a));
    cpu_req_valid <= 1'b0;
    check({16'h0, fills - f0}, {16'h0, nf});
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_lru();
    fetch(A, 1'b1, 16'h1);
    apb(1'b0, cnt(0, 1), 0);
    check(r, 32'h0);
    apb(1'b1, CB + 32'h500, 32'h1);
    fetch(A, 1'b1, 16'h1);
    fetch(A + 32'h8, 1'b1, 16'h0);
    fetch(A + 32'h400, 1'b1, 16'h1);
    fetch(A, 1'b1, 16'h0);
    fetch(A + 32'h800, 1'b1, 16'h1);
    fetch(A, 1'b1, 16'h0);
    fetch(A + 32'h400, 1'b1, 16'h1);
    fetch(32'h10000040, 1'b0, 16'h1);
    fetch(32'h10000040, 1'b0, 16'h0);
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, cnt(0, k), 0);
      check(r, k == 0 ? 32'h3 : k == 1 ? 32'h4 : 32'h0);
      apb(1'b0, cnt(1, k), 0);
      check(r, k > 1 ? 32'h1 : 32'h0);
    end
    $display("test lru done");
  endtask
  task automatic t_content();
    logic [31:0] i0, i1, base;
    apb(1'b0, INFO_REGION_BASE + 32'h80, 0);
    i0 = r;
    apb(1'b0, INFO_REGION_BASE + 32'h84, 0);
    i1 = r;
    check({31'h0, e}, 32'h0);
    check({30'h0, i0[31], i1[31]}, 32'h3);
    check(32'(i0[21:0]) + 32'(i1[21:0]), 32'h1);
    check({30'h0, i0[30], i1[30]}, 32'h2);
    base = DATA_REGION_BASE + 32'h210;
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, base + 32'(k * 4), 0);
      check(r, exp_word({A[31:4], 4'h0} + 32'(k * 4)));
    end
    apb(1'b1, base, 32'h1);
    check({31'h0, e}, 32'h1);
    apb(1'b1, INFO_REGION_BASE, 32'h1);
    check({31'h0, e}, 32'h1);
    apb(1'b0, 32'h00F10000, 0);
    check({31'h0, e}, 32'h1);
    apb(1'b1, CB + 32'h518, 32'h1);
    apb(1'b0, base, 0);
    check({31'h0, e}, 32'h1);
    apb(1'b1, CB + 32'h518, 32'h0);
    $display("test content done");
  endtask
  task automatic t_freeze_clear();
    apb(1'b1, CB + 32'h520, 32'h1);
    fetch(A + 32'hC00, 1'b1, 16'h1);
    fetch(A + 32'hC00, 1'b1, 16'h1);
    fetch(A, 1'b1, 16'h0);
    apb(1'b1, CB + 32'h520, 32'h0);
    apb(1'b1, CB + 32'h510, 32'h1);
    apb(1'b0, cnt(0, 0), 0);
    check(r, 32'h0);
    fetch(A, 1'b1, 16'h0);
    apb(1'b0, cnt(0, 0), 0);
    check(r, 32'h1);
    $display("test freeze and clear done");
  endtask
  task automatic t_invalidate();
    for (int c = 0; c < 2; c++) begin
      if (c == 0) apb(1'b1, CB + 32'h504, 32'h1);
      else apb(1'b1, CB + 32'h500, 32'h0);
      apb(1'b1, CB + 32'h500, 32'h1);
      fetch(A, 1'b1, 16'h1);
      fetch(A, 1'b1, 16'h0);
    end
    $display("test invalidate done");
  endtask
  task automatic t_ram();
    apb(1'b1, CB + 32'h514, 32'h1);
    apb(1'b0, DATA_REGION_BASE + 32'h200, 0);
    check(r, 32'h0);
    apb(1'b1, DATA_REGION_BASE + 32'h7F0, 32'hC0DE1234);
    apb(1'b0, DATA_REGION_BASE + 32'h7F0, 0);
    check(r, 32'hC0DE1234);
    fetch(A, 1'b1, 16'h1);
    fetch(A, 1'b1, 16'h1);
    apb(1'b1, CB + 32'h514, 32'h0);
    fetch(A, 1'b1, 16'h1);
    fetch(A, 1'b1, 16'h0);
    $display("test ram mode done");
  endtask
  // ----------------------------------------------------------------
  // clock, reset and sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, cpu_req_valid} = '0;
    paddr = '0;
    pwdata = '0;
    cpu_req = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_lru();
    t_content();
    t_freeze_clear();
    t_invalidate();
    t_ram();
    give_verdict();
  end
endmodule
`default_nettype wire
